// ===== hw/mcsrg_cfg.svh
// Constants of the mode control and security row guard
`ifndef MCSRG_CFG_SVH
`define MCSRG_CFG_SVH

`define MCSRG_EE_AW      16
`define MCSRG_ROW_BASE   16'hff80
`define MCSRG_FAB_BASE   16'hff00

`define MCSRG_A_MODE     8'h00
`define MCSRG_A_CTRL     8'h04
`define MCSRG_A_ROW_IDX  8'h08
`define MCSRG_A_ROW_DATA 8'h0c
`define MCSRG_A_STATUS   8'h10
`define MCSRG_A_MODE_REQ 8'h14

`define MCSRG_RO_END     7'h20
`define MCSRG_WP_END     7'h30
`define MCSRG_WO_END     7'h50
`define MCSRG_FUSE_IDX   7'h7f
`define MCSRG_HIDDEN     8'h00

`define MCSRG_F_DELIV    0
`define MCSRG_F_CDOPT    1
`define MCSRG_F_CDIS     2
`define MCSRG_F_WPLK     3

`define MCSRG_B_SF       0
`define MCSRG_B_SSF      1
`define MCSRG_B_CFG_CALL 0
`define MCSRG_B_SYS_CALL 1
`define MCSRG_B_CD_WPLK  0
`define MCSRG_B_CD_CDIS  1

`define MCSRG_SSF_RST    1'b1
`define MCSRG_SF_RST     1'b0

`endif

// ===== hw/mcsrg_pkg.sv
// Types of the mode control and security row guard
`include "mcsrg_cfg.svh"
package mcsrg_pkg;

    typedef enum logic [2:0] {
        md_boot    = 3'h0,
        md_test    = 3'h1,
        md_special = 3'h2,
        md_system  = 3'h3,
        md_user    = 3'h4
    } mcsrg_mode_t;

    typedef enum logic [1:0] {
        sup_boot    = 2'h0,
        sup_test    = 2'h1,
        sup_special = 2'h2,
        sup_none    = 2'h3
    } mcsrg_super_t;

    typedef enum logic [1:0] {
        ph_fetch = 2'h0,
        ph_load  = 2'h1,
        ph_run   = 2'h2,
        ph_halt  = 2'h3
    } mcsrg_phase_t;

    typedef struct packed {
        logic [`MCSRG_EE_AW-1:0] addr;
        logic [7:0]              wdata;
        logic                    we;
        logic                    rd;
    } mcsrg_ee_t;

    typedef struct packed {
        mcsrg_phase_t phase;
        logic         ssf;
        logic         sf;
        mcsrg_super_t sup;
        mcsrg_mode_t  mode;
        logic         run;
        logic [7:0]   fuse;
        logic [7:0]   row_idx;
        logic [7:0]   latch;
        logic [1:0]   fetch;
        logic         refused;
        mcsrg_ee_t    ee;
        logic [31:0]  rdata;
    } mcsrg_state_t;

endpackage

// ===== hw/mcsrg_byte_policy.sv
// Write merge and read visibility of one protected row byte
`timescale 1ns/1ns
`include "mcsrg_cfg.svh"
module mcsrg_byte_policy (
    // Byte position and contents
    input  wire logic [6:0] idx,
    input  wire logic [7:0] old_byte,
    input  wire logic [7:0] new_byte,
    // Privilege and lock
    input  wire logic       test_mode,
    input  wire logic       wp_locked,
    // Result
    output logic      [7:0] merged,
    output logic            visible
);
    always_comb begin
        merged  = old_byte;
        visible = 1'b1;
        if (idx < `MCSRG_RO_END) begin
            if (test_mode) begin
                merged = new_byte;
            end
        end else if (idx < `MCSRG_WP_END) begin
            if (test_mode || !wp_locked) begin
                merged = new_byte;
            end
        end else if (idx < `MCSRG_WO_END) begin
            // Only ones can be added; test mode is held to the same limit
            merged = old_byte | new_byte;
        end else begin
            // Configuration bytes: hidden outside test mode, settable in test only
            visible = test_mode;
            if (test_mode) begin
                merged = old_byte | new_byte;
            end
        end
    end
endmodule

// ===== hw/mcsrg_guard.sv
// Mode control and security row guard, top level
`timescale 1ns/1ns
`include "mcsrg_cfg.svh"
module mcsrg_guard import mcsrg_pkg::*; (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset,
    // Hardware test availability
    input  wire logic                    test_hw_avail,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // EEPROM port
    output logic      [`MCSRG_EE_AW-1:0] ee_addr,
    output logic      [7:0]              ee_wdata,
    output logic                         ee_we,
    output logic                         ee_rd,
    input  wire logic [7:0]              ee_rdata,
    // Mode and configuration
    output mcsrg_mode_t                  cpu_mode,
    output logic                         cpu_run,
    output logic      [1:0]              mode_status_word,
    output logic      [7:0]              fuse_cfg
);
    mcsrg_state_t s;
    mcsrg_state_t next_s;
    logic [7:0]   pol_merged;
    logic         pol_visible;
    logic         in_test;

    assign in_test = (s.mode == md_test);

    ////////////////////////////////////////////////////////////////////////
    // Row byte policy

    mcsrg_byte_policy u_policy (
        .idx       (s.row_idx[6:0]),
        .old_byte  (s.latch),
        .new_byte  (reg_wdata[7:0]),
        .test_mode (in_test),
        .wp_locked (s.fuse[`MCSRG_F_WPLK]),
        .merged    (pol_merged),
        .visible   (pol_visible)
    );

    function automatic logic [`MCSRG_EE_AW-1:0] row_addr(input logic [7:0] idx);
        // Bit 7 selects the factory init area below the protected row
        if (idx[7]) begin
            row_addr = `MCSRG_FAB_BASE | {9'h000, idx[6:0]};
        end else begin
            row_addr = `MCSRG_ROW_BASE | {9'h000, idx[6:0]};
        end
    endfunction

    function automatic mcsrg_mode_t mode_of(input logic ssf, input logic sf,
                                            input mcsrg_super_t sup);
        if (ssf) begin
            unique case (sup)
                sup_boot:  mode_of = md_boot;
                sup_test:  mode_of = md_test;
                default:   mode_of = md_special;
            endcase
        end else if (sf) begin
            mode_of = md_system;
        end else begin
            mode_of = md_user;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [7:0] nf;
        logic       t_ok;
        logic       blocked;
        nf      = s.fuse;
        t_ok    = 1'b0;
        blocked = 1'b0;
        next_s          = s;
        next_s.ee.we    = 1'b0;
        next_s.ee.rd    = 1'b0;
        next_s.rdata    = 32'h0000_0000;
        next_s.fetch    = {s.fetch[0], 1'b0};
        unique case (s.phase)
            ph_fetch: begin
                next_s.ee.rd   = 1'b1;
                next_s.ee.addr = row_addr({1'b0, `MCSRG_FUSE_IDX});
                next_s.fetch   = 2'b01;
                next_s.phase   = ph_load;
            end
            ph_load: begin
                if (s.fetch[1]) begin
                    next_s.fuse = ee_rdata;
                    t_ok    = test_hw_avail && !ee_rdata[`MCSRG_F_DELIV];
                    blocked = ee_rdata[`MCSRG_F_CDOPT] && ee_rdata[`MCSRG_F_CDIS];
                    if (blocked) begin
                        next_s.phase = ph_halt;
                    end else if (t_ok) begin
                        next_s.phase = ph_run;
                        next_s.sup   = sup_test;
                        next_s.run   = 1'b1;
                    end else begin
                        next_s.phase = ph_run;
                        next_s.sup   = sup_special;
                        next_s.ssf   = 1'b0;
                        next_s.sf    = 1'b1;
                        next_s.run   = 1'b1;
                    end
                end
            end
            ph_run: begin
                if (s.fetch[1]) begin
                    next_s.latch = ee_rdata;
                end
                // Registers answer only once boot is over, so boot stays unseen
                if (reg_wr) begin
                    unique case (reg_addr)
                        `MCSRG_A_MODE: begin
                            next_s.ssf = s.ssf & reg_wdata[`MCSRG_B_SSF];
                            next_s.sf  = s.sf & reg_wdata[`MCSRG_B_SF];
                        end
                        `MCSRG_A_MODE_REQ: begin
                            next_s.refused = 1'b0;
                            if (reg_wdata[`MCSRG_B_CFG_CALL]) begin
                                next_s.ssf = 1'b1;
                            end
                            if (reg_wdata[`MCSRG_B_SYS_CALL] && s.mode == md_user) begin
                                next_s.sf = 1'b1;
                            end
                            unique case (mcsrg_super_t'(reg_wdata[3:2]))
                                sup_boot: begin
                                    next_s.refused = 1'b1;
                                end
                                sup_test: begin
                                    if (s.sup == sup_boot && !s.fuse[`MCSRG_F_DELIV]) begin
                                        next_s.sup = sup_test;
                                    end else begin
                                        next_s.refused = 1'b1;
                                    end
                                end
                                sup_special: begin
                                    next_s.sup = sup_special;
                                end
                                sup_none: begin
                                end
                            endcase
                        end
                        `MCSRG_A_CTRL: begin
                            if (reg_wdata[`MCSRG_B_CD_WPLK]) begin
                                nf[`MCSRG_F_WPLK] = 1'b1;
                            end
                            if (reg_wdata[`MCSRG_B_CD_CDIS] && s.fuse[`MCSRG_F_CDOPT]) begin
                                nf[`MCSRG_F_CDIS] = 1'b1;
                            end
                            if (nf != s.fuse) begin
                                next_s.fuse     = nf;
                                next_s.ee.we    = 1'b1;
                                next_s.ee.addr  = row_addr({1'b0, `MCSRG_FUSE_IDX});
                                next_s.ee.wdata = nf;
                                if (s.row_idx == {1'b0, `MCSRG_FUSE_IDX}) begin
                                    next_s.latch = nf;
                                end
                            end
                        end
                        `MCSRG_A_ROW_IDX: begin
                            next_s.row_idx = reg_wdata[7:0];
                            next_s.ee.rd   = 1'b1;
                            next_s.ee.addr = row_addr(reg_wdata[7:0]);
                            next_s.fetch   = 2'b01;
                        end
                        `MCSRG_A_ROW_DATA: begin
                            if (s.row_idx[7]) begin
                                nf = reg_wdata[7:0];
                            end else begin
                                nf = pol_merged;
                            end
                            // A write that changes nothing is dropped quietly
                            if (nf != s.latch) begin
                                next_s.latch    = nf;
                                next_s.ee.we    = 1'b1;
                                next_s.ee.addr  = row_addr(s.row_idx);
                                next_s.ee.wdata = nf;
                                if (s.row_idx == {1'b0, `MCSRG_FUSE_IDX}) begin
                                    next_s.fuse = nf;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (reg_rd) begin
                    unique case (reg_addr)
                        `MCSRG_A_MODE: begin
                            next_s.rdata[1:0] = {s.ssf, s.sf};
                        end
                        `MCSRG_A_CTRL: begin
                            next_s.rdata[1:0] = {s.fuse[`MCSRG_F_CDIS], s.fuse[`MCSRG_F_WPLK]};
                        end
                        `MCSRG_A_ROW_IDX: begin
                            next_s.rdata[7:0] = s.row_idx;
                        end
                        `MCSRG_A_ROW_DATA: begin
                            if (s.row_idx[7] || pol_visible) begin
                                next_s.rdata[7:0] = s.latch;
                            end else begin
                                next_s.rdata[7:0] = `MCSRG_HIDDEN;
                            end
                        end
                        `MCSRG_A_STATUS: begin
                            next_s.rdata[7:0] = {1'b0, s.refused, s.fuse[`MCSRG_F_DELIV],
                                                 s.sup, s.mode};
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ph_halt: begin
            end
        endcase
        next_s.mode = mode_of(next_s.ssf, next_s.sf, next_s.sup);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s <= '{phase:   ph_fetch,
                   ssf:     `MCSRG_SSF_RST,
                   sf:      `MCSRG_SF_RST,
                   sup:     sup_boot,
                   mode:    md_boot,
                   run:     1'b0,
                   fuse:    8'h00,
                   row_idx: 8'h00,
                   latch:   8'h00,
                   fetch:   2'h0,
                   refused: 1'b0,
                   ee:      '0,
                   rdata:   32'h0000_0000};
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata        = s.rdata;
    assign ee_addr          = s.ee.addr;
    assign ee_wdata         = s.ee.wdata;
    assign ee_we            = s.ee.we;
    assign ee_rd            = s.ee.rd;
    assign cpu_mode         = s.mode;
    assign cpu_run          = s.run;
    assign mode_status_word = {s.ssf, s.sf};
    assign fuse_cfg         = s.fuse;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [2:0] cyc;
    logic       ee_in_row;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cyc <= 3'h0;
        end else if (cyc != 3'h7) begin
            cyc <= cyc + 3'h1;
        end
    end
    assign ee_in_row = (ee_addr[15:7] == `MCSRG_ROW_BASE >> 7);

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_boot_first: assert property ((cyc == 3'h0) |-> (cpu_mode == md_boot && !cpu_run))
        else $error("first cycle after reset not in hidden boot mode");
    a_boot_exit: assert property ((s.phase == ph_load && s.fetch[1] && test_hw_avail
                                   && ee_rdata[2:0] == 3'h0)
                                  |=> (cpu_mode == md_test && cpu_run))
        else $error("boot did not enter available test mode");
    a_no_boot_back: assert property ((cpu_mode != md_boot) |=> (cpu_mode != md_boot))
        else $error("mode returned to boot");
    a_test_entry: assert property ($rose(cpu_mode == md_test)
                                   |-> ($past(cpu_mode) == md_boot
                                        && !$past(ee_rdata[`MCSRG_F_DELIV])))
        else $error("test mode entered other than from boot before release");
    a_boot_hidden: assert property (cpu_run |-> (cpu_mode != md_boot))
        else $error("boot mode active while running");
    a_super_special: assert property ((cpu_run && s.ssf && cpu_mode != md_test)
                                      |-> (cpu_mode == md_special))
        else $error("super flag outside test did not mean special mode");
    a_fuse_fixed: assert property ((cpu_run && cpu_mode != md_test
                                    && $past(cpu_mode) != md_test && $past(cpu_run))
                                   |-> ($stable(fuse_cfg[`MCSRG_F_DELIV])
                                        && $stable(fuse_cfg[`MCSRG_F_CDOPT])))
        else $error("security fuse changed by software");
    a_ro_kept: assert property ((ee_we && ee_in_row && $past(cpu_mode) != md_test)
                                |-> (ee_addr[6:0] >= `MCSRG_RO_END))
        else $error("read-only row byte written");
    a_wp_kept: assert property ((ee_we && ee_in_row && $past(s.fuse[`MCSRG_F_WPLK])
                                 && $past(cpu_mode) != md_test)
                                |-> !(ee_addr[6:0] >= `MCSRG_RO_END
                                      && ee_addr[6:0] < `MCSRG_WP_END))
        else $error("locked row byte written");
    a_wo_mono: assert property ((ee_we && ee_in_row && ee_addr[6:0] >= `MCSRG_WP_END
                                 && ee_addr[6:0] < `MCSRG_WO_END)
                                |-> ((ee_wdata & $past(s.latch)) == $past(s.latch)))
        else $error("write-once bit cleared");
    a_halt_holds: assert property ((s.phase == ph_halt) |=> !cpu_run [*4])
        else $error("disabled card started");
    a_user_exact: assert property (cpu_run |-> ((mode_status_word == 2'h0)
                                               == (cpu_mode == md_user)))
        else $error("user mode does not match flags");
    a_flags_clear: assert property ((reg_wr && reg_addr == `MCSRG_A_MODE)
                                    |=> ((mode_status_word & ~$past(mode_status_word))
                                         == 2'h0))
        else $error("flag write raised privilege");

    c_test_run: cover property (cpu_run && cpu_mode == md_test);
    c_special: cover property (cpu_run && cpu_mode == md_special);
    c_halted: cover property (s.phase == ph_halt);
    c_wo_write: cover property (ee_we && ee_in_row && ee_addr[6:0] == `MCSRG_WP_END);
endmodule

// ===== sim/mcsrg_ee_model.sv
// Behavioural EEPROM holding the top 256 bytes behind the guard
`timescale 1ns/1ns
module mcsrg_ee_model #(
    parameter logic [7:0] FUSE_INIT = 8'h02
) (
    // Clock
    input  wire logic        clock,
    // Access port
    input  wire logic [15:0] ee_addr,
    input  wire logic [7:0]  ee_wdata,
    input  wire logic        ee_we,
    input  wire logic        ee_rd,
    output logic      [7:0]  ee_rdata
);
    logic [7:0] mem [0:255];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        mem[255] = FUSE_INIT;
        ee_rdata = 8'h00;
    end
    always @(posedge clock) begin
        if (ee_we && ee_addr[15:8] == 8'hff) begin
            mem[ee_addr[7:0]] <= ee_wdata;
        end
        // Read data stands one cycle; after that the bus toggles
        if (ee_rd) begin
            ee_rdata <= (ee_addr[15:8] == 8'hff) ? mem[ee_addr[7:0]] : ~ee_addr[7:0];
        end else begin
            ee_rdata <= ~ee_rdata;
        end
    end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the mode control and security row guard
`timescale 1ns/1ns
`include "mcsrg_cfg.svh"
module tb_top import mcsrg_pkg::*;;
    logic        clock;
    logic        reset;
    logic        test_hw_avail;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [15:0] ee_addr;
    logic [7:0]  ee_wdata;
    logic        ee_we;
    logic        ee_rd;
    logic [7:0]  ee_rdata;
    mcsrg_mode_t cpu_mode;
    logic        cpu_run;
    logic [1:0]  mode_status_word;
    logic [7:0]  fuse_cfg;
    logic        rd_seen = 1'b0;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    logic [7:0]  r;
    integer      seed = 32'h259e330a;
    int          num_errors = 0;
    int          tests_run = 0;

    mcsrg_guard i_dut (.clock(clock), .reset(reset), .test_hw_avail(test_hw_avail),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_we(ee_we),
        .ee_rd(ee_rd), .ee_rdata(ee_rdata), .cpu_mode(cpu_mode), .cpu_run(cpu_run),
        .mode_status_word(mode_status_word), .fuse_cfg(fuse_cfg));
    mcsrg_ee_model i_ee (.clock(clock), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
        .ee_we(ee_we), .ee_rd(ee_rd), .ee_rdata(ee_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back({m, e & m});
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask
    task automatic row_wr(input logic [7:0] idx, input logic [7:0] d);
        wr(`MCSRG_A_ROW_IDX, {24'h0, idx});
        idle(2);
        wr(`MCSRG_A_ROW_DATA, {24'h0, d});
        idle(2);
    endtask
    task automatic row_rd(input logic [7:0] idx, input logic [7:0] e);
        wr(`MCSRG_A_ROW_IDX, {24'h0, idx});
        idle(2);
        rd(`MCSRG_A_ROW_DATA, 32'hffffffff, {24'h0, e});
    endtask
    task automatic start(input logic avail);
        reset <= 1'b1;
        test_hw_avail <= avail;
        repeat (10) @(posedge clock);
        check("boot_mode", 32'(cpu_mode), 32'(md_boot));
        check("reset_flags", 32'(mode_status_word), 32'h2);
        reset <= 1'b0;
        idle(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read results are compared against the oldest note
    always @(posedge clock) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            check("reg_rdata", reg_rdata & note[63:32], note[31:0]);
        end
        rd_seen <= reg_rd;
    end
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        test_hw_avail = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        start(1'b1);
        check("test_entry", 32'(cpu_mode), 32'(md_test));
        row_wr(8'h05, 8'ha5);
        row_rd(8'h05, 8'ha5);
        wr(`MCSRG_A_MODE_REQ, 32'h0);
        rd(`MCSRG_A_STATUS, 32'h47, 32'h41);
        // Let the pending read answer be compared before reset clears it
        repeat (2) @(posedge clock);
        i_ee.mem[255] = 8'h03;
        start(1'b1);
        check("system_entry", 32'(cpu_mode), 32'(md_system));
        check("system_flags", 32'(mode_status_word), 32'h1);
        check("system_run", 32'(cpu_run), 32'h1);
        wr(`MCSRG_A_MODE_REQ, 32'h4);
        rd(`MCSRG_A_STATUS, 32'h67, 32'h63);
        wr(`MCSRG_A_MODE_REQ, 32'h9);
        idle(2);
        check("special", 32'(cpu_mode), 32'(md_special));
        check("super_flag", 32'(mode_status_word[1]), 32'h1);
        rd(`MCSRG_A_STATUS, 32'h47, 32'h02);
        wr(`MCSRG_A_MODE, 32'h1);
        idle(2);
        check("clear_super", 32'(mode_status_word), 32'h1);
        wr(`MCSRG_A_MODE, 32'h3);
        idle(2);
        check("no_raise", 32'(mode_status_word), 32'h1);
        wr(`MCSRG_A_MODE, 32'h0);
        idle(2);
        check("user", 32'(cpu_mode), 32'(md_user));
        wr(`MCSRG_A_MODE_REQ, 32'he);
        idle(2);
        check("sys_call", 32'(cpu_mode), 32'(md_system));
        row_wr(8'h05, 8'hff);
        row_rd(8'h05, 8'ha5);
        r = 8'($random(seed));
        row_wr(8'h20, r);
        row_rd(8'h20, r);
        wr(`MCSRG_A_CTRL, 32'h1);
        idle(2);
        row_wr(8'h20, ~r);
        row_rd(8'h20, r);
        rd(`MCSRG_A_CTRL, 32'h1, 32'h1);
        r = 8'($random(seed));
        row_wr(8'h30, r);
        row_rd(8'h30, 8'hea | r);
        row_wr(8'h30, 8'h00);
        row_rd(8'h30, 8'hea | r);
        row_rd(8'h50, 8'h00);
        row_wr(8'h7f, 8'h00);
        check("fuse_kept", 32'(fuse_cfg[1:0]), 32'h3);
        row_rd(8'h7f, 8'h00);
        row_wr(8'h90, 8'h3c);
        row_rd(8'h90, 8'h3c);
        rd(8'h18, 32'hffffffff, 32'h0);
        wr(`MCSRG_A_CTRL, 32'h3);
        idle(2);
        check("card_off", 32'(fuse_cfg[2]), 32'h1);
        start(1'b0);
        check("halt_run", 32'(cpu_run), 32'h0);
        check("halt_mode", 32'(cpu_mode), 32'(md_boot));
        rd(`MCSRG_A_STATUS, 32'hffffffff, 32'h0);
        idle(3);
        conclude();
    end
endmodule
